// ### shared/modem_seq_pkg.sv
// Purpose: Shared constants and types for the modem mode sequencer and its host end
// Assumes: 125 MHz clock; command bytes arrive as single-cycle strobes
// Notes:   Long timings are module parameters so simulation can shorten them
package modem_seq_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // Command codes
  localparam logic [7:0] CMD_SYS_RESET  = 8'h01;
  localparam logic [7:0] CMD_OFF_MODE   = 8'h05;
  localparam logic [7:0] CMD_WRITE_TX   = 8'h07;
  localparam logic [7:0] CMD_GET_STATUS = 8'h0A;
  localparam logic [7:0] CMD_SEND       = 8'h0D;
  localparam logic [7:0] CMD_SEND_RECV  = 8'h0E;
  localparam logic [7:0] CMD_KEY_READ   = 8'h0F;
  localparam logic [7:0] CMD_READ_RX    = 8'h10;
  localparam logic [7:0] CMD_IDENT_READ = 8'h12;

  // Buffer sizes in bytes
  localparam int unsigned TX_BYTES  = 12;
  localparam int unsigned RX_BYTES  = 8;
  localparam int unsigned KEY_BYTES = 16;
  localparam int unsigned ID_BYTES  = 4;

  // Status error code reported after a downlink
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_NO_DATA = 4'h1;

  // Timings, in their own units
  localparam longint unsigned PIN_MIN_US     = 10;
  localparam longint unsigned INIT_EU_MS     = 10;
  localparam longint unsigned INIT_US_MS     = 30;
  localparam longint unsigned TX_EU_MS       = 7_500;
  localparam longint unsigned TX_US_MS       = 2_500;
  localparam longint unsigned RX_WAIT_S      = 20;
  localparam longint unsigned RX_WINDOW_S    = 30;
  localparam longint unsigned FIRST_EXTRA_MS = 5;

  // Cycle counts
  localparam longint unsigned PIN_MIN_CYC     = (PIN_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint unsigned INIT_EU_CYC     = INIT_EU_MS * CLK_HZ / 1_000;
  localparam longint unsigned INIT_US_CYC     = INIT_US_MS * CLK_HZ / 1_000;
  localparam longint unsigned TX_EU_CYC       = TX_EU_MS * CLK_HZ / 1_000;
  localparam longint unsigned TX_US_CYC       = TX_US_MS * CLK_HZ / 1_000;
  localparam longint unsigned RX_WAIT_CYC     = RX_WAIT_S * CLK_HZ;
  localparam longint unsigned RX_WINDOW_CYC   = RX_WINDOW_S * CLK_HZ;
  localparam longint unsigned FIRST_EXTRA_CYC = FIRST_EXTRA_MS * CLK_HZ / 1_000;

  localparam int unsigned CNT_W = 34;
  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_RESET,
    MODE_INIT,
    MODE_IDLE,
    MODE_TX,
    MODE_RX_WAIT,
    MODE_RX
  } mode_t;

endpackage

// ### shared/modem_link_if.sv
// Purpose: Link between host and modem: wake and reset pins, command strobes, event line
// Assumes: Both ends on one clock; pins are plain levels here
// Notes:   Read data is returned byte by byte on rsp_valid
`timescale 1ns/1ps
interface modem_link_if;
  logic       wake_pin_high;
  logic [5:0] wake_pin_group_low;
  logic       ext_hold_reset_low;
  logic       cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic       cmd_last;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       event_line_low;

  modport device (
    input  wake_pin_high, wake_pin_group_low, ext_hold_reset_low, cmd_valid, cmd_code, cmd_data, cmd_last,
    output rsp_valid, rsp_data, event_line_low
  );
  modport host (
    output wake_pin_high, wake_pin_group_low, ext_hold_reset_low, cmd_valid, cmd_code, cmd_data, cmd_last,
    input  rsp_valid, rsp_data, event_line_low
  );
endinterface // modem_link_if

// ### logic/sync_2ff.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module sync_2ff #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sync_2ff

// ### logic/modem_mode_sequencer.sv
// Purpose: Device end: operating modes, power sequencing, event line, buffers
// Assumes: Commands arrive as one-cycle strobes; pins are asynchronous
// Notes:   Radio activity is modelled by timers only
// Summary of operation
// - Starts in off mode, ignores commands
// - Wake pin starts power-on, event then idle
// - Send frame transmits, events, returns idle
// - Status read releases the event line
// - Send/receive: uplink, wait 20 s, receive
// - Receive up to 30 s, then event
// - Error zero means 8-byte telegram readable
// - Off mode ignores reset pin and command
// - Wake triggers reset; host may hold reset
// - Host holds pins at least 10 us
// - Init done about 10/30 ms after release
// - Idle persists after wake pins drop
// - First power-up and send take longer
// - Host drops wake pins before off command
// - Host clears event before off command
// - Off refused while any wake pin active
// - Host loads up to 12 bytes first
// - Uplink event after 7-8 s EU, 2-3 s US
// - Send/receive event 50 s after uplink ends
// - Key and identifier readable by command
`timescale 1ns/1ps
module modem_mode_sequencer
  import modem_seq_pkg::*;
#(
  parameter cnt_t INIT_EU     = cnt_t'(INIT_EU_CYC),
  parameter cnt_t INIT_US     = cnt_t'(INIT_US_CYC),
  parameter cnt_t TX_EU       = cnt_t'(TX_EU_CYC),
  parameter cnt_t TX_US       = cnt_t'(TX_US_CYC),
  parameter cnt_t RX_WAIT     = cnt_t'(RX_WAIT_CYC),
  parameter cnt_t RX_WINDOW   = cnt_t'(RX_WINDOW_CYC),
  parameter cnt_t FIRST_EXTRA = cnt_t'(FIRST_EXTRA_CYC),
  parameter logic [31:0]  DEVICE_IDENT = 32'h0000_0001,   // Arbitrary value
  parameter logic [127:0] REG_KEY      = 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link
  modem_link_if.device    link,
  // Configuration and radio outcome
  input  wire logic       region_eu,
  input  wire logic       downlink_ok,
  input  wire logic [7:0] downlink_byte,
  // Status
  output logic [2:0]      mode,
  output logic [3:0]      err_code
);
  logic       wake_hi_s;
  logic [5:0] wake_lo_s;
  logic       rst_lo_s;

  sync_2ff #(.W(8), .RST_VAL(8'h7E)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({link.wake_pin_high, link.wake_pin_group_low, link.ext_hold_reset_low}),
    .sync_out ({wake_hi_s, wake_lo_s, rst_lo_s})
  );

  mode_t      mode_q, mode_d;
  cnt_t       cnt_q;
  logic       event_q;
  logic       first_init_q, first_send_q;
  logic [3:0] err_q;
  logic [7:0] tx_buf [TX_BYTES];
  logic [7:0] rx_buf [RX_BYTES];
  logic [3:0] tx_idx_q;
  logic [4:0] rd_idx_q;
  logic [7:0] rd_cmd_q;
  logic       rsp_valid_q;
  logic [7:0] rsp_data_q;

  wire wake_any   = wake_hi_s | ~(&wake_lo_s);
  wire cmd        = link.cmd_valid && mode_q != MODE_OFF && mode_q != MODE_RESET;
  wire is_cmd_status = cmd && link.cmd_code == CMD_GET_STATUS;
  wire is_cmd_reset  = cmd && link.cmd_code == CMD_SYS_RESET;
  wire is_cmd_off    = cmd && link.cmd_code == CMD_OFF_MODE;
  wire idle       = mode_q == MODE_IDLE;
  wire go_send    = idle && cmd && link.cmd_code == CMD_SEND;
  wire go_sendrx  = idle && cmd && link.cmd_code == CMD_SEND_RECV;
  wire cnt_done   = cnt_q == '0;
  wire [7:0] rd_len = rd_cmd_q == CMD_READ_RX ? 8'(RX_BYTES) :
                      rd_cmd_q == CMD_KEY_READ ? 8'(KEY_BYTES) : 8'(ID_BYTES);
  wire rd_start   = idle && cmd && link.cmd_code inside {CMD_READ_RX, CMD_KEY_READ, CMD_IDENT_READ};

  function automatic cnt_t with_extra(input cnt_t base, input logic first);
    with_extra = first ? cnt_t'(base + FIRST_EXTRA) : base;
  endfunction

  // Done of a timed phase that ends with an event
  // Uplink of a send/receive raises no event; only the receive end does
  wire phase_end = cnt_done && (mode_q == MODE_INIT || mode_q == MODE_RX ||
                                (mode_q == MODE_TX && rd_cmd_q != CMD_SEND_RECV));

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_OFF:     if (wake_any) mode_d = MODE_RESET;
      MODE_RESET:   if (rst_lo_s) mode_d = MODE_INIT;
      MODE_INIT:    if (cnt_done) mode_d = MODE_IDLE;
      MODE_IDLE: begin
        if (go_send || go_sendrx) mode_d = MODE_TX;
        else if (is_cmd_off && !wake_any) mode_d = MODE_OFF;
      end
      MODE_TX:      if (cnt_done) mode_d = rd_cmd_q == CMD_SEND_RECV ? MODE_RX_WAIT : MODE_IDLE;
      MODE_RX_WAIT: if (cnt_done) mode_d = MODE_RX;
      MODE_RX:      if (cnt_done) mode_d = MODE_IDLE;
      default:      mode_d = MODE_OFF;
    endcase
    // System reset command and pin restart init, except in off mode
    if (is_cmd_reset || (!rst_lo_s && mode_q != MODE_OFF)) mode_d = MODE_RESET;
  end

  wire [7:0] rd_byte = rd_cmd_q == CMD_READ_RX ? rx_buf[rd_idx_q[2:0]] :
                       rd_cmd_q == CMD_KEY_READ ? REG_KEY[8'(rd_idx_q) * 8 +: 8] :
                       DEVICE_IDENT[8'(rd_idx_q[1:0]) * 8 +: 8];

  // Mode and phase timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q       <= MODE_OFF;
      cnt_q        <= '0;
      first_init_q <= 1'b1;
      first_send_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      if (mode_d != mode_q) begin
        unique case (mode_d)
          MODE_INIT:    cnt_q <= with_extra(region_eu ? INIT_EU : INIT_US, first_init_q);
          MODE_TX:      cnt_q <= with_extra(region_eu ? TX_EU : TX_US, first_send_q);
          MODE_RX_WAIT: cnt_q <= RX_WAIT;
          MODE_RX:      cnt_q <= RX_WINDOW;
          default:      cnt_q <= '0;
        endcase
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (mode_q == MODE_INIT && cnt_done) first_init_q <= 1'b0;
      if (go_send || go_sendrx) first_send_q <= 1'b0;
    end
  end

  // Event flag and downlink outcome; set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_q <= 1'b0;
      err_q   <= ERR_NONE;
    end else begin
      if (phase_end) event_q <= 1'b1;
      else if (is_cmd_status || mode_d == MODE_OFF || mode_d == MODE_RESET) event_q <= 1'b0;
      if (mode_q == MODE_RX && cnt_done) begin
        err_q <= downlink_ok ? ERR_NONE : ERR_NO_DATA;
      end
    end
  end

  // Transmit buffer load, limited to its size
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_idx_q <= '0;
    end else if (idle && cmd && link.cmd_code == CMD_WRITE_TX) begin
      if (tx_idx_q < 4'(TX_BYTES)) begin
        tx_buf[tx_idx_q] <= link.cmd_data;
        tx_idx_q         <= tx_idx_q + 1'b1;
      end
      if (link.cmd_last) tx_idx_q <= '0;
    end
  end

  // Receive capture and read responses share one index
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_idx_q    <= '0;
      rd_cmd_q    <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      if (go_send || go_sendrx) rd_cmd_q <= link.cmd_code;
      if (mode_q == MODE_RX && downlink_ok && rd_idx_q < 5'(RX_BYTES)) begin
        rx_buf[rd_idx_q[2:0]] <= downlink_byte;
        rd_idx_q              <= rd_idx_q + 1'b1;
      end else if (mode_d == MODE_RX && mode_q != MODE_RX) begin
        rd_idx_q <= '0;
      end
      // One byte per cycle
      rsp_valid_q <= 1'b0;
      if (rd_start) begin
        rd_cmd_q    <= link.cmd_code;
        rd_idx_q    <= '0;
        rsp_valid_q <= 1'b0;
      end else if (idle && rd_cmd_q inside {CMD_READ_RX, CMD_KEY_READ, CMD_IDENT_READ}
                   && 8'(rd_idx_q) < rd_len) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= rd_byte;
        rd_idx_q    <= rd_idx_q + 1'b1;
      end
    end
  end

  assign link.rsp_valid      = rsp_valid_q;
  assign link.rsp_data       = rsp_data_q;
  assign link.event_line_low = ~event_q;
  assign mode                = mode_q;
  assign err_code            = err_q;
endmodule // modem_mode_sequencer

// ### logic/modem_host_ctrl.sv
// Purpose: Host end: drives wake and reset pins and issues commands in legal order
// Assumes: User requests are one-cycle pulses taken only when busy is low
// Notes:   Pin hold time is counted before reset release
`timescale 1ns/1ps
module modem_host_ctrl
  import modem_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link
  modem_link_if.host      link,
  // User side
  input  wire logic       power_up,
  input  wire logic       power_down,
  input  wire logic       send_req,
  input  wire logic       sendrx_req,
  input  wire logic [7:0] payload_byte,
  output logic            busy,
  output logic            done,
  output logic            event_seen
);
  typedef enum logic [2:0] {H_OFF, H_WAKE, H_WAIT_EV, H_READY, H_LOAD, H_DOWN} hstate_t;

  hstate_t    st_q;
  cnt_t       cnt_q;
  logic [3:0] idx_q;
  logic       mode_rx_q;
  logic       done_q;
  logic       clr_sent_q;
  logic       ev_s;

  sync_2ff #(.W(1), .RST_VAL(1'b1)) u_sync_ev (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (link.event_line_low),
    .sync_out (ev_s)
  );

  wire ev_pending = ~ev_s;
  wire in_wake    = st_q != H_OFF && st_q != H_DOWN;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q      <= H_OFF;
      cnt_q     <= '0;
      idx_q     <= '0;
      mode_rx_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        H_OFF: if (power_up) begin
          st_q  <= H_WAKE;
          cnt_q <= cnt_t'(PIN_MIN_CYC);
        end
        H_WAKE: if (cnt_q == '0) st_q <= H_WAIT_EV;
                else cnt_q <= cnt_q - 1'b1;
        H_WAIT_EV: if (ev_pending) begin
          st_q   <= H_READY;
          done_q <= 1'b1;
        end
        H_READY: begin
          if (power_down) begin
            // Wake pins stay inactive long enough for the device to see them
            st_q  <= H_DOWN;
            cnt_q <= cnt_t'(PIN_MIN_CYC);
          end else if ((send_req || sendrx_req) && !ev_pending) begin
            st_q      <= H_LOAD;
            idx_q     <= '0;
            mode_rx_q <= sendrx_req;
          end
        end
        H_LOAD: if (idx_q == 4'(TX_BYTES)) st_q <= H_WAIT_EV;
                else idx_q <= idx_q + 1'b1;
        H_DOWN: if (cnt_q == '0) st_q <= H_OFF;
                else cnt_q <= cnt_q - 1'b1;
        default: st_q <= H_OFF;
      endcase
    end
  end

  // Command strobes are decoded from state
  wire clear_ev  = ev_pending && !clr_sent_q && (st_q == H_READY);
  wire load_byte = st_q == H_LOAD && idx_q < 4'(TX_BYTES);
  wire fire_send = st_q == H_LOAD && idx_q == 4'(TX_BYTES);
  wire fire_off  = st_q == H_DOWN && cnt_q == '0;

  // One status read per event; the synced line lags the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clr_sent_q <= 1'b0;
    end else if (clear_ev) begin
      clr_sent_q <= 1'b1;
    end else if (!ev_pending) begin
      clr_sent_q <= 1'b0;
    end
  end

  assign link.wake_pin_high      = in_wake;
  assign link.wake_pin_group_low = 6'h3F;
  assign link.ext_hold_reset_low = st_q != H_WAKE;
  assign link.cmd_valid          = clear_ev | load_byte | fire_send | fire_off;
  assign link.cmd_code           = clear_ev  ? CMD_GET_STATUS :
                                   load_byte ? CMD_WRITE_TX :
                                   fire_send ? (mode_rx_q ? CMD_SEND_RECV : CMD_SEND) : CMD_OFF_MODE;
  assign link.cmd_data           = payload_byte;
  assign link.cmd_last           = load_byte && idx_q == 4'(TX_BYTES - 1);
  assign busy                    = st_q != H_READY && st_q != H_OFF;
  assign done                    = done_q;
  assign event_seen              = ev_pending;
endmodule // modem_host_ctrl

// ### sim/modem_link_checker.sv
// Purpose: Concurrent checks on the link between host end and modem end
// Assumes: One clock; sys_rst synchronous, active high
// Notes:   INIT_LIM must cover the slowest init plus the first-run extra
`timescale 1ns/1ps
module modem_link_checker
  import modem_seq_pkg::*;
#(
  parameter int INIT_LIM = 150
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Link
  input wire logic       wake_pin_high,
  input wire logic [5:0] wake_pin_group_low,
  input wire logic       ext_hold_reset_low,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       event_line_low
);
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  wire         wake_on    = wake_pin_high || (wake_pin_group_low != 6'h3F);
  wire         status_cmd = cmd_valid && (cmd_code == CMD_GET_STATUS);
  wire         off_cmd    = cmd_valid && (cmd_code == CMD_OFF_MODE);
  wire         send_cmd   = cmd_valid && ((cmd_code == CMD_SEND) || (cmd_code == CMD_SEND_RECV));

  // Saturates so a stuck pin cannot wrap into a short count
  assign hold_d = ext_hold_reset_low ? 16'h0000 : ((hold_q == 16'hFFFF) ? hold_q : hold_q + 16'h0001);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_q <= 16'h0000;
    end else begin
      hold_q <= hold_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence pin_released;
    $rose(ext_hold_reset_low);
  endsequence
  sequence init_event;
    ##[1:INIT_LIM] !event_line_low;
  endsequence

  pin_hold_a: assert property (pin_released |-> hold_q >= PIN_MIN_CYC)
    else $error("reset pin released too early");
  wake_first_a: assert property (pin_released |-> wake_on)
    else $error("reset released without wake pin");
  init_event_a: assert property (pin_released |-> init_event)
    else $error("no init event after reset release");
  status_clears_a: assert property (status_cmd |-> ##[1:2] event_line_low)
    else $error("status read left event line low");
  event_holds_a: assert property (!event_line_low && !cmd_valid && ext_hold_reset_low |=> !event_line_low)
    else $error("event line released without status read");
  status_wait_a: assert property (status_cmd |-> !event_line_low)
    else $error("status read with no pending event");
  send_wait_a: assert property (send_cmd |-> event_line_low)
    else $error("send issued while event pending");
  off_order_a: assert property (off_cmd |-> !wake_on)
    else $error("off command while wake pin active");
  off_clear_a: assert property (off_cmd |-> event_line_low)
    else $error("off command while event pending");
endmodule // modem_link_checker

// ### sim/test_modem_mode_sequencer.sv
// Purpose: Self-checking bench: sequencer facing host end, plus a bench-driven second link
// Assumes: Shortened timing parameters; bounds allow a few cycles for pin synchronisers
// Notes:   Second link breaks host rules on purpose to see refusals
`timescale 1ns/1ps
module test_modem_mode_sequencer
  import modem_seq_pkg::*;
;
  localparam int P_INIT_EU = 40;
  localparam int P_INIT_US = 80;
  localparam int P_TX_EU   = 60;
  localparam int P_TX_US   = 30;
  localparam int P_RX_WAIT = 50;
  localparam int P_RX_WIN  = 70;
  localparam int P_EXTRA   = 10;
  localparam int SLACK     = 12;
  localparam logic [31:0]  B_IDENT = 32'h1234_00A7; // Arbitrary value
  localparam logic [127:0] B_KEY   = 128'h0000_00C3; // Arbitrary value

  logic       clk, sys_rst, region_eu, downlink_ok;
  logic [7:0] downlink_byte, payload_byte;
  logic       power_up, power_down, send_req, sendrx_req, busy, done, event_seen;
  logic [2:0] mode, mode_b;
  logic [3:0] err_code, err_b;
  int         n_fail, total_checks, n_done;

  modem_link_if link();
  modem_link_if link_b();

  modem_mode_sequencer #(.INIT_EU(cnt_t'(P_INIT_EU)), .INIT_US(cnt_t'(P_INIT_US)), .TX_EU(cnt_t'(P_TX_EU)),
    .TX_US(cnt_t'(P_TX_US)), .RX_WAIT(cnt_t'(P_RX_WAIT)), .RX_WINDOW(cnt_t'(P_RX_WIN)),
    .FIRST_EXTRA(cnt_t'(P_EXTRA))) u_modem_mode_sequencer (.clk(clk), .sys_rst(sys_rst), .link(link),
    .region_eu(region_eu), .downlink_ok(downlink_ok), .downlink_byte(downlink_byte), .mode(mode), .err_code(err_code));
  modem_mode_sequencer #(.INIT_EU(cnt_t'(P_INIT_EU)), .INIT_US(cnt_t'(P_INIT_US)), .TX_EU(cnt_t'(P_TX_EU)),
    .TX_US(cnt_t'(P_TX_US)), .RX_WAIT(cnt_t'(P_RX_WAIT)), .RX_WINDOW(cnt_t'(P_RX_WIN)),
    .FIRST_EXTRA(cnt_t'(P_EXTRA)), .DEVICE_IDENT(B_IDENT), .REG_KEY(B_KEY)) u_modem_mode_sequencer_b (.clk(clk),
    .sys_rst(sys_rst), .link(link_b), .region_eu(region_eu), .downlink_ok(downlink_ok),
    .downlink_byte(downlink_byte), .mode(mode_b), .err_code(err_b));
  modem_host_ctrl u_modem_host_ctrl (.clk(clk), .sys_rst(sys_rst), .link(link), .power_up(power_up),
    .power_down(power_down), .send_req(send_req), .sendrx_req(sendrx_req), .payload_byte(payload_byte),
    .busy(busy), .done(done), .event_seen(event_seen));
  modem_link_checker #(.INIT_LIM(150)) u_modem_link_checker (.clk(clk), .sys_rst(sys_rst),
    .wake_pin_high(link.wake_pin_high), .wake_pin_group_low(link.wake_pin_group_low),
    .ext_hold_reset_low(link.ext_hold_reset_low), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
    .event_line_low(link.event_line_low));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    payload_byte  <= payload_byte + 8'h01;
    downlink_byte <= downlink_byte + 8'h03;
  end
  always @(negedge clk) if (done === 1'b1) n_done++;

  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %0t %s: %0d outside %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  // Negedge sampling keeps clear of the edge that updates the line
  task automatic wait_evt(input logic lvl, input int lim, output int n);
    n = 0;
    while (link.event_line_low !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_cmd(input logic [7:0] code, output int n);
    n = 0;
    while (!(link.cmd_valid === 1'b1 && link.cmd_code === code) && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic power_up_seq();
    int n;
    @(posedge clk) power_up <= 1'b1;
    region_eu <= 1'b1;
    @(posedge clk) power_up <= 1'b0;
    // Host pins are read only once its state has settled
    @(negedge clk);
    n = 0;
    while (link.ext_hold_reset_low !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
      if (n == 200) chk_eq(mode, MODE_RESET, "held in reset");
    end
    wait_evt(1'b0, 400, n);
    chk_rng(n, P_INIT_EU - 1, P_INIT_EU + P_EXTRA + SLACK, "init time");
    wait_evt(1'b1, 40, n);
    chk_eq(link.event_line_low, 1'b1, "init event cleared");
    chk_eq(mode, MODE_IDLE, "idle after init");
    chk_eq(busy, 1'b0, "host ready");
  endtask

  task automatic send_seq(input logic eu, input int tx);
    int n;
    @(posedge clk) region_eu <= eu;
    @(posedge clk) send_req <= 1'b1;
    @(posedge clk) send_req <= 1'b0;
    wait_cmd(CMD_SEND, n);
    chk_rng(n, 12, 99, "buffer load before send");
    repeat (3) @(negedge clk);
    chk_eq(mode, MODE_TX, "transmitting");
    chk_eq(busy, 1'b1, "host waits for event");
    wait_evt(1'b0, 4 * tx, n);
    chk_rng(n + 3, tx - 1, tx + P_EXTRA + SLACK, "uplink time");
    chk_eq(mode, MODE_IDLE, "idle after send");
    repeat (2) @(negedge clk);
    chk_eq(event_seen, 1'b1, "host sees event");
    wait_evt(1'b1, 40, n);
    chk_eq(link.event_line_low, 1'b1, "send event cleared");
  endtask

  task automatic sendrx_seq(input logic ok, input logic [3:0] exp_err);
    int   n, t_r;
    logic saw_w;
    @(posedge clk) region_eu <= 1'b1;
    downlink_ok <= ok;
    @(posedge clk) sendrx_req <= 1'b1;
    @(posedge clk) sendrx_req <= 1'b0;
    wait_cmd(CMD_SEND_RECV, n);
    n = 0;
    t_r = 0;
    saw_w = 1'b0;
    while (link.event_line_low !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
      if (mode === MODE_RX_WAIT) saw_w = 1'b1;
      if (mode === MODE_RX && t_r == 0) t_r = n;
    end
    chk_eq(saw_w, 1'b1, "wait before receive");
    chk_rng(t_r, P_TX_EU + P_RX_WAIT - 1, P_TX_EU + P_RX_WAIT + P_EXTRA + SLACK, "receive opens");
    chk_rng(n - t_r, ok ? 1 : P_RX_WIN - 1, P_RX_WIN + SLACK, "receive window");
    chk_eq(err_code, exp_err, "downlink error code");
    wait_evt(1'b1, 60, n);
    chk_eq(link.event_line_low, 1'b1, "downlink event cleared");
  endtask

  task automatic power_down_seq();
    int n;
    @(posedge clk) power_down <= 1'b1;
    @(posedge clk) power_down <= 1'b0;
    n = 0;
    while (mode !== MODE_OFF && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk_eq(mode, MODE_OFF, "off after power down");
    chk_eq(event_seen, 1'b0, "no event left at off");
  endtask

  task automatic cmd_b(input logic [7:0] code, output int nrsp, output logic [7:0] first);
    @(posedge clk) link_b.cmd_valid <= 1'b1;
    link_b.cmd_code <= code;
    link_b.cmd_last <= 1'b1;
    @(posedge clk) link_b.cmd_valid <= 1'b0;
    nrsp = 0;
    first = 8'h00;
    repeat (48) begin
      @(negedge clk);
      if (link_b.rsp_valid === 1'b1) begin
        if (nrsp == 0) first = link_b.rsp_data;
        nrsp++;
      end
    end
  endtask

  task automatic rogue_seq();
    int         n;
    logic [7:0] f;
    @(posedge clk) region_eu <= 1'b0;
    cmd_b(CMD_KEY_READ, n, f);
    chk_eq(n, 0, "read answered in off");
    @(posedge clk) link_b.ext_hold_reset_low <= 1'b0;
    cmd_b(CMD_SYS_RESET, n, f);
    chk_eq(mode_b, MODE_OFF, "reset ignored in off");
    @(posedge clk) link_b.wake_pin_group_low <= 6'h37;
    repeat (PIN_MIN_CYC + 50) @(posedge clk);
    @(negedge clk) chk_eq(mode_b, MODE_RESET, "held by reset pin");
    @(posedge clk) link_b.ext_hold_reset_low <= 1'b1;
    n = 0;
    while (link_b.event_line_low !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_rng(n, P_INIT_US - 1, P_INIT_US + P_EXTRA + SLACK, "init time us");
    cmd_b(CMD_GET_STATUS, n, f);
    chk_eq(link_b.event_line_low, 1'b1, "status clears event");
    @(posedge clk) link_b.wake_pin_group_low <= 6'h3F;
    repeat (10) @(negedge clk);
    chk_eq(mode_b, MODE_IDLE, "idle without wake");
    cmd_b(CMD_KEY_READ, n, f);
    chk_eq({n[7:0], f}, {8'h10, B_KEY[7:0]}, "key read");
    cmd_b(CMD_IDENT_READ, n, f);
    chk_eq({n[7:0], f}, {8'h04, B_IDENT[7:0]}, "ident read");
    cmd_b(CMD_READ_RX, n, f);
    chk_eq(n, RX_BYTES, "receive buffer length");
    @(posedge clk) link_b.wake_pin_high <= 1'b1;
    repeat (5) @(posedge clk);
    cmd_b(CMD_OFF_MODE, n, f);
    chk_eq(mode_b, MODE_IDLE, "off refused while awake");
    @(posedge clk) link_b.wake_pin_high <= 1'b0;
    repeat (5) @(posedge clk);
    cmd_b(CMD_OFF_MODE, n, f);
    chk_eq(mode_b, MODE_OFF, "off accepted");
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    {clk, region_eu, downlink_ok, power_up, power_down, send_req, sendrx_req} = '0;
    sys_rst = 1'b1;
    downlink_byte = 8'hA5;
    payload_byte = 8'h3C;
    n_fail = 0;
    total_checks = 0;
    n_done = 0;
    {link_b.wake_pin_high, link_b.cmd_valid, link_b.cmd_code, link_b.cmd_data, link_b.cmd_last} = '0;
    link_b.wake_pin_group_low = 6'h3F;
    link_b.ext_hold_reset_low = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk) chk_eq(mode, MODE_OFF, "off after supply");
    power_up_seq();
    send_seq(1'b1, P_TX_EU);
    send_seq(1'b0, P_TX_US);
    sendrx_seq(1'b1, ERR_NONE);
    sendrx_seq(1'b0, ERR_NO_DATA);
    power_down_seq();
    rogue_seq();
    chk_eq(n_done, 5, "host done pulses");
    end_sim();
  end

  // Whole run needs well under 10,000 cycles
  initial begin
    #200us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule // test_modem_mode_sequencer
